//--- src/ugs_line_mon.sv
// Bus line monitor: suspend, resume and bus reset detection
`timescale 1ns/100ps
module ugs_line_mon #(
	parameter logic [17:0] SUSPEND_CYCLES = 18'(ugs_pkg::SUSPEND_CYCLES)
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [1:0] line_state_i,
	output logic suspended_o,
	output logic sleep_entry_o,
	output logic sleep_exit_o,
	output logic bus_reset_o
);

	ugs_pkg::ugs_link_t link_state;
	logic [17:0] idle_cnt;
	logic [7:0] se0_cnt;
	logic [1:0] prev_line;
	logic wake_edge;
	logic reset_seen;

	////////////////////////////////////////////////////////////////////////////
	// Line history and counters
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prev_line <= ugs_pkg::LINE_J;
		end else begin
			prev_line <= line_state_i;
		end
	end

	// Idle J counts toward suspend; saturates so suspend is entered once
	always_ff @(posedge clk_i) begin
		if (reset_i || line_state_i != ugs_pkg::LINE_J) begin
			idle_cnt <= '0;
		end else if (idle_cnt != SUSPEND_CYCLES) begin
			idle_cnt <= idle_cnt + 18'h0_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || line_state_i != ugs_pkg::LINE_SE0) begin
			se0_cnt <= '0;
		end else if (se0_cnt != 8'(ugs_pkg::BUS_RESET_CYCLES)) begin
			se0_cnt <= se0_cnt + 8'h01;
		end
	end

	assign wake_edge = prev_line == ugs_pkg::LINE_J && line_state_i == ugs_pkg::LINE_K;
	assign reset_seen = se0_cnt == 8'(ugs_pkg::BUS_RESET_CYCLES);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bus_reset_o <= 1'b0;
		end else begin
			bus_reset_o <= reset_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Suspend state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			link_state <= ugs_pkg::UGS_LINK_ACTIVE;
			sleep_entry_o <= 1'b0;
			sleep_exit_o <= 1'b0;
		end else begin
			sleep_entry_o <= 1'b0;
			sleep_exit_o <= 1'b0;
			unique case (link_state)
				ugs_pkg::UGS_LINK_ACTIVE: begin
					// Entry only on the full count of idle samples, never one short
					if (idle_cnt == SUSPEND_CYCLES - 18'h0_0001
						&& line_state_i == ugs_pkg::LINE_J) begin
						link_state <= ugs_pkg::UGS_LINK_SUSPENDED;
						sleep_entry_o <= 1'b1;
					end
				end
				ugs_pkg::UGS_LINK_SUSPENDED: begin
					// A long SE0 also wakes the function, as a host reset must
					if (wake_edge || reset_seen) begin
						link_state <= ugs_pkg::UGS_LINK_ACTIVE;
						sleep_exit_o <= 1'b1;
					end
				end
			endcase
		end
	end

	assign suspended_o = link_state == ugs_pkg::UGS_LINK_SUSPENDED;

	chk_idle_before_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
		sleep_entry_o |-> $past(idle_cnt) == SUSPEND_CYCLES - 18'h0_0001
		&& $past(line_state_i) == ugs_pkg::LINE_J)
		else $error("suspend entered without full idle time");

	chk_wake_on_jk: assert property (@(posedge clk_i) disable iff (reset_i)
		(sleep_exit_o && !$past(reset_seen)) |->
		($past(line_state_i) == ugs_pkg::LINE_K && $past(line_state_i, 2) == ugs_pkg::LINE_J))
		else $error("resume without J to K change");

endmodule

//--- src/ugs_pkg.sv
// Shared constants and types for the USB global control and status registers
package ugs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses in processor data space
	localparam logic [15:0] ADDR_MASK = 16'hf001;
	localparam logic [15:0] ADDR_STATUS = 16'hf002;
	localparam logic [15:0] ADDR_RESET_STATUS = 16'hf003;
	localparam logic [15:0] ADDR_PAIRING = 16'hf004;
	localparam logic [15:0] ADDR_DMA_LOW = 16'hf005;
	localparam logic [15:0] ADDR_DMA_HIGH = 16'hf006;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_PROTOCOL = 6;
	localparam int BIT_BUS_RESET_LIVE = 3;
	localparam int BIT_SLEEP_EXIT = 2;
	localparam int BIT_SLEEP_ENTRY = 1;
	localparam int BIT_RESET_REQUEST = 0;
	localparam int BIT_SLEEP_ENTRY_EN = 1;
	localparam int BIT_WAKEUP_EN = 0;
	localparam logic [7:0] MASK_WRITABLE = 8'h43;
	localparam logic [7:0] PAIR_WRITABLE = 8'h0e;
	localparam logic [7:0] DMA_HIGH_WRITABLE = 8'h7f;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [31:0] EP_ADDR_RESET = 32'h7654_3210;

	////////////////////////////////////////////////////////////////////////////
	// Bus line states as seen from the transceiver
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J = 2'h1;
	localparam logic [1:0] LINE_K = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SUSPEND_IDLE_MS = 3;
	localparam int SUSPEND_CYCLES = (SUSPEND_IDLE_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int BUS_RESET_NS = 2500;
	localparam int BUS_RESET_CYCLES = (BUS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_COUNT_W = 18;
	localparam int SE0_COUNT_W = 8;

	typedef enum logic {
		UGS_LINK_ACTIVE,
		UGS_LINK_SUSPENDED
	} ugs_link_t;

endpackage

//--- src/ugs_regs.sv
// USB global interrupt, status, pairing and DMA address registers
`timescale 1ns/100ps

// Function
// - Mask bit 6 lets protocol-handler events raise the interrupt.
// - Mask bit 1 raises the interrupt on suspend entry.
// - Suspend entered only after at least 3 ms bus idle.
// - Mask bit 0 raises the interrupt on resume.
// - A J to K line change is the resume signal.
// - Reading master status clears its event bits 2:0 after returning the value.
// - Status bit 6 is high while any protocol status bit is set.
// - Status bit 3 follows the live bus reset level.
// - Reset status bit 3 mirrors bus reset; reading it clears nothing.
// - Status bit 2 set when suspend is left.
// - Status bit 1 set when suspend is entered.
// - Status bit 0 set when the bus enters reset.
// - Reserved bits read as zero.
// - Pairing bits 3:1 join an IN and OUT endpoint on one address.
// - Bits 1,2,3 give endpoints 4,5,6 addresses of endpoints 1,2,3.
// - Low DMA register holds target address bits 7:0.
// - High DMA register bits 6:0 form target address bits 14:8.
module ugs_regs #(
	parameter logic [17:0] SUSPEND_CYCLES = 18'(ugs_pkg::SUSPEND_CYCLES)
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [1:0] line_state_i,
	input wire logic [7:0] protocol_event_status_i,
	output logic [7:0] rdata_o,
	output logic irq_o,
	output logic suspended_o,
	output logic [3:1] endpoint_pair_select_o,
	output logic [14:0] dma_target_address_o,
	output logic [31:0] ep_bus_addr_o
);

	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	logic [7:0] usb_interrupt_mask;
	logic [3:1] endpoint_pair_select;
	logic [7:0] dma_target_addr_low;
	logic [6:0] dma_target_addr_high;
	logic sleep_exit_flag;
	logic sleep_entry_flag;
	logic reset_request_flag;
	logic bus_reset_prev;
	logic mon_suspended;
	logic sleep_entry;
	logic sleep_exit;
	logic bus_reset;
	logic reset_start;
	logic protocol_pending;
	logic status_read;
	logic [7:0] status_value;
	logic [7:0] next_rdata;
	logic next_irq;

	////////////////////////////////////////////////////////////////////////////
	// Bus line monitor
	ugs_line_mon #(
		.SUSPEND_CYCLES(SUSPEND_CYCLES)
	) u_line_mon (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.line_state_i(line_state_i),
		.suspended_o(mon_suspended),
		.sleep_entry_o(sleep_entry),
		.sleep_exit_o(sleep_exit),
		.bus_reset_o(bus_reset)
	);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			suspended_o <= 1'b0;
			bus_reset_prev <= 1'b0;
		end else begin
			suspended_o <= mon_suspended;
			bus_reset_prev <= bus_reset;
		end
	end

	assign reset_start = bus_reset && !bus_reset_prev;
	assign protocol_pending = |protocol_event_status_i;
	assign status_read = rd_i && addr_i == ugs_pkg::ADDR_STATUS;

	////////////////////////////////////////////////////////////////////////////
	// Software writable registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			usb_interrupt_mask <= ugs_pkg::RESET_VALUE;
		end else if (wr_i && addr_i == ugs_pkg::ADDR_MASK) begin
			usb_interrupt_mask <= wdata_i & ugs_pkg::MASK_WRITABLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			endpoint_pair_select <= ugs_pkg::RESET_VALUE[3:1];
		end else if (wr_i && addr_i == ugs_pkg::ADDR_PAIRING) begin
			endpoint_pair_select <= wdata_i[3:1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dma_target_addr_low <= ugs_pkg::RESET_VALUE;
		end else if (wr_i && addr_i == ugs_pkg::ADDR_DMA_LOW) begin
			dma_target_addr_low <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dma_target_addr_high <= ugs_pkg::RESET_VALUE[6:0];
		end else if (wr_i && addr_i == ugs_pkg::ADDR_DMA_HIGH) begin
			dma_target_addr_high <= wdata_i[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky event flags; a new event wins over the clearing read
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sleep_exit_flag <= 1'b0;
			sleep_entry_flag <= 1'b0;
			reset_request_flag <= 1'b0;
		end else begin
			sleep_exit_flag <= sleep_exit || (sleep_exit_flag && !status_read);
			sleep_entry_flag <= sleep_entry || (sleep_entry_flag && !status_read);
			reset_request_flag <= reset_start || (reset_request_flag && !status_read);
		end
	end

	always_comb begin
		status_value = 8'h00;
		status_value[ugs_pkg::BIT_PROTOCOL] = protocol_pending;
		status_value[ugs_pkg::BIT_BUS_RESET_LIVE] = bus_reset;
		status_value[ugs_pkg::BIT_SLEEP_EXIT] = sleep_exit_flag;
		status_value[ugs_pkg::BIT_SLEEP_ENTRY] = sleep_entry_flag;
		status_value[ugs_pkg::BIT_RESET_REQUEST] = reset_request_flag;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, registered; unmapped addresses return zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (addr_i)
			ugs_pkg::ADDR_MASK: begin
				next_rdata = usb_interrupt_mask;
			end
			ugs_pkg::ADDR_STATUS: begin
				next_rdata = status_value;
			end
			ugs_pkg::ADDR_RESET_STATUS: begin
				next_rdata[ugs_pkg::BIT_BUS_RESET_LIVE] = bus_reset;
			end
			ugs_pkg::ADDR_PAIRING: begin
				next_rdata = {4'h0, endpoint_pair_select, 1'b0};
			end
			ugs_pkg::ADDR_DMA_LOW: begin
				next_rdata = dma_target_addr_low;
			end
			ugs_pkg::ADDR_DMA_HIGH: begin
				next_rdata = {1'b0, dma_target_addr_high};
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= ugs_pkg::RESET_VALUE;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt line; bus reset has no enable of its own, so it interrupts only by ending suspend, under mask bit 0
	always_comb begin
		next_irq = (usb_interrupt_mask[ugs_pkg::BIT_PROTOCOL] && protocol_pending)
			|| (usb_interrupt_mask[ugs_pkg::BIT_SLEEP_ENTRY_EN] && sleep_entry_flag)
			|| (usb_interrupt_mask[ugs_pkg::BIT_WAKEUP_EN] && sleep_exit_flag);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pairing and DMA address outputs
	// Paired endpoint address moves with endpoint_pair_select_o, one cycle after the pairing register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ep_bus_addr_o <= ugs_pkg::EP_ADDR_RESET;
		end else begin
			for (int i = 0; i < 8; i++) begin
				ep_bus_addr_o[i*4 +: 4] <= 4'(i);
			end
			for (int p = 1; p < 4; p++) begin
				if (endpoint_pair_select[p]) begin
					ep_bus_addr_o[(p+3)*4 +: 4] <= 4'(p);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			endpoint_pair_select_o <= ugs_pkg::RESET_VALUE[3:1];
			dma_target_address_o <= 15'h0000;
		end else begin
			endpoint_pair_select_o <= endpoint_pair_select;
			dma_target_address_o <= {dma_target_addr_high, dma_target_addr_low};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_protocol_irq_on: assert property (
		(protocol_pending && usb_interrupt_mask[ugs_pkg::BIT_PROTOCOL]) |=> irq_o)
		else $error("protocol event with enable did not interrupt");

	chk_sleep_irq_on: assert property (
		(sleep_entry && usb_interrupt_mask[ugs_pkg::BIT_SLEEP_ENTRY_EN]
		&& !(wr_i && addr_i == ugs_pkg::ADDR_MASK)) |=> ##1 irq_o)
		else $error("suspend entry with enable did not interrupt");

	chk_wake_irq_on: assert property (
		(sleep_exit && usb_interrupt_mask[ugs_pkg::BIT_WAKEUP_EN]
		&& !(wr_i && addr_i == ugs_pkg::ADDR_MASK)) |=> ##1 irq_o)
		else $error("resume with enable did not interrupt");

	chk_read_clears: assert property (
		(status_read && !sleep_exit && !sleep_entry && !reset_start) |=>
		(!sleep_exit_flag && !sleep_entry_flag && !reset_request_flag))
		else $error("status read did not clear flags");

	chk_protocol_bit: assert property (
		status_read |=> rdata_o[ugs_pkg::BIT_PROTOCOL] == $past(protocol_pending))
		else $error("protocol status bit wrong");

	chk_reset_mirror: assert property (
		(rd_i && addr_i == ugs_pkg::ADDR_RESET_STATUS && sleep_entry_flag) |=>
		(rdata_o == {4'h0, $past(bus_reset), 3'h0} && sleep_entry_flag))
		else $error("reset status read wrong or cleared status");

	chk_event_wins: assert property (
		(status_read && sleep_entry) |=> sleep_entry_flag)
		else $error("event lost against clearing read");

	chk_pair_ep4: assert property (
		endpoint_pair_select[1] |=> ep_bus_addr_o[19:16] == 4'h1)
		else $error("endpoint 4 not given address 1");

	chk_irq_cause: assert property (
		irq_o == $past(|(usb_interrupt_mask & {1'b0, protocol_pending, 4'h0,
		sleep_entry_flag, sleep_exit_flag})))
		else $error("interrupt does not follow enabled events");

	chk_live_reset_bit: assert property (
		status_read |=> rdata_o[ugs_pkg::BIT_BUS_RESET_LIVE] == $past(bus_reset))
		else $error("live bus reset bit wrong");

	chk_exit_flag_set: assert property (
		sleep_exit |=> sleep_exit_flag)
		else $error("suspend exit not recorded");

	chk_entry_flag_set: assert property (
		sleep_entry |=> sleep_entry_flag)
		else $error("suspend entry not recorded");

	chk_reset_flag_set: assert property (
		reset_start |=> reset_request_flag)
		else $error("bus reset not recorded");

	chk_status_reserved: assert property (
		status_read |=> (rdata_o & 8'hb0) == 8'h00)
		else $error("reserved status bits not zero");

	chk_mask_reserved: assert property (
		(rd_i && addr_i == ugs_pkg::ADDR_MASK) |=>
		(rdata_o & ~ugs_pkg::MASK_WRITABLE) == 8'h00)
		else $error("reserved mask bits not zero");

	chk_dma_low_byte: assert property (
		(wr_i && addr_i == ugs_pkg::ADDR_DMA_LOW) |=> ##1
		dma_target_address_o[7:0] == $past(wdata_i, 2))
		else $error("dma low byte not carried to target address");

	chk_dma_high_bits: assert property (
		(wr_i && addr_i == ugs_pkg::ADDR_DMA_HIGH) |=> ##1
		dma_target_address_o[14:8] == $past(wdata_i[6:0], 2))
		else $error("dma high bits not carried to target address");

	chk_pair_ep6: assert property (
		endpoint_pair_select[3] |=> ep_bus_addr_o[27:24] == 4'h3)
		else $error("endpoint 6 not given address 3");

endmodule

//--- tb/tb_ugs_regs.sv
// Self-checking bench for the USB global status registers
`timescale 1ns/100ps
module tb_ugs_regs;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] pe_status = 8'h00;
	logic [1:0] line_state;
	logic [7:0] rdata_o;
	logic irq_o;
	logic suspended_o;
	logic [3:1] pair_o;
	logic [14:0] dma_o;
	logic [31:0] ep_o;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;

	////////////////////////////////////////
	always #10 clk_i = ~clk_i;
	ugs_host_model i_ugs_host_model (.clk_i(clk_i), .line_state_o(line_state));
	// Short idle count keeps the suspend tests brief
	ugs_regs #(.SUSPEND_CYCLES(18'h0_0014)) i_ugs_regs (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.addr_i(addr_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.wdata_i(wdata_i),
		.line_state_i(line_state),
		.protocol_event_status_i(pe_status),
		.rdata_o(rdata_o),
		.irq_o(irq_o),
		.suspended_o(suspended_o),
		.endpoint_pair_select_o(pair_o),
		.dma_target_address_o(dma_o),
		.ep_bus_addr_o(ep_o)
	);

	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(negedge clk_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		chk(rdata_o, exp, what);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	////////////////////////////////////////
	task automatic t_reset;
		chk(ep_o, 32'h7654_3210, "ep addr reset");
		for (int a = 16'hf000; a <= 16'hf007; a++) begin
			rd(16'(a), 8'h00, "reset read");
		end
		$display("test reset done");
	endtask
	task automatic t_write;
		logic [7:0] exp [7] = '{8'h43, 8'h00, 8'h00, 8'h0e, 8'hff, 8'h7f, 8'h00};
		for (int a = 0; a < 7; a++) begin
			wr(16'hf001 + 16'(a), 8'hff);
		end
		for (int a = 0; a < 7; a++) begin
			rd(16'hf001 + 16'(a), exp[a], "ones read");
		end
		repeat (2) @(negedge clk_i);
		chk(dma_o, 15'h7fff, "dma all");
		chk(pair_o, 3'h7, "pair all");
		chk(ep_o, 32'h7321_3210, "ep all paired");
		chk(irq_o, 1'b0, "irq quiet");
		// Firmware pairs endpoints 1 and 3 only, lower one as OUT
		wr(ugs_pkg::ADDR_PAIRING, 8'h0a);
		wr(ugs_pkg::ADDR_DMA_LOW, 8'h5a);
		wr(ugs_pkg::ADDR_DMA_HIGH, 8'h81);
		repeat (2) @(negedge clk_i);
		chk(ep_o, 32'h7351_3210, "ep two pairs");
		chk(dma_o, 15'h015a, "dma mixed");
		$display("test write done");
	endtask
	task automatic t_protocol;
		wr(ugs_pkg::ADDR_MASK, 8'h00);
		pe_status = 8'h10;
		repeat (3) @(negedge clk_i);
		chk(irq_o, 1'b0, "irq masked");
		rd(ugs_pkg::ADDR_STATUS, 8'h40, "proto bit");
		rd(ugs_pkg::ADDR_STATUS, 8'h40, "proto live");
		wr(ugs_pkg::ADDR_MASK, 8'h40);
		repeat (3) @(negedge clk_i);
		chk(irq_o, 1'b1, "irq proto");
		pe_status = 8'h00;
		repeat (3) @(negedge clk_i);
		chk(irq_o, 1'b0, "irq proto gone");
		rd(ugs_pkg::ADDR_STATUS, 8'h00, "proto clear");
		$display("test protocol done");
	endtask
	task automatic t_suspend;
		wr(ugs_pkg::ADDR_MASK, 8'h03);
		fork
			i_ugs_host_model.hold(ugs_pkg::LINE_J, 50);
			begin
				repeat (15) @(negedge clk_i);
				chk(suspended_o, 1'b0, "early suspend");
				// Read the status in the very cycle of the entry pulse
				while (!i_ugs_regs.sleep_entry) @(negedge clk_i);
				addr_i = ugs_pkg::ADDR_STATUS;
				rd_i = 1'b1;
				@(negedge clk_i);
				rd_i = 1'b0;
				chk(rdata_o, 8'h00, "read with entry");
				chk(suspended_o, 1'b1, "suspend");
				rd(ugs_pkg::ADDR_RESET_STATUS, 8'h00, "mirror keeps flag");
				chk(irq_o, 1'b1, "irq suspend");
				rd(ugs_pkg::ADDR_STATUS, 8'h02, "entry flag");
				repeat (3) @(negedge clk_i);
				chk(irq_o, 1'b0, "irq after read");
			end
		join
		// Free traffic resumes with a J to K change
		repeat (6) @(negedge clk_i);
		chk(suspended_o, 1'b0, "resumed");
		chk(irq_o, 1'b1, "irq resume");
		rd(ugs_pkg::ADDR_STATUS, 8'h04, "exit flag");
		$display("test suspend done");
	endtask
	task automatic t_bus_reset;
		fork
			i_ugs_host_model.hold(ugs_pkg::LINE_SE0, 150);
			begin
				repeat (120) @(negedge clk_i);
				rd(ugs_pkg::ADDR_RESET_STATUS, 8'h00, "short se0");
				repeat (12) @(negedge clk_i);
				rd(ugs_pkg::ADDR_RESET_STATUS, 8'h08, "mirror");
				rd(ugs_pkg::ADDR_STATUS, 8'h09, "reset flags");
				rd(ugs_pkg::ADDR_STATUS, 8'h08, "live only");
			end
		join
		repeat (5) @(negedge clk_i);
		rd(ugs_pkg::ADDR_RESET_STATUS, 8'h00, "mirror off");
		rd(ugs_pkg::ADDR_STATUS, 8'h00, "reset over");
		$display("test bus reset done");
	endtask

	////////////////////////////////////////
	initial begin
		repeat (10) @(negedge clk_i);
		reset_i = 1'b0;
		t_reset();
		t_write();
		t_protocol();
		t_suspend();
		t_bus_reset();
		results();
	end
endmodule

//--- tb/ugs_host_model.sv
// Far-end host model that drives the bus line state
`timescale 1ns/100ps
module ugs_host_model (
	input wire logic clk_i,
	output logic [1:0] line_state_o
);
	////////////////////////////////////////
	logic hold_en = 1'b0;
	logic [1:0] hold_state = ugs_pkg::LINE_J;
	initial line_state_o = ugs_pkg::LINE_J;
	// Free traffic toggles J and K so the idle timer never expires
	always @(negedge clk_i) begin
		if (hold_en) begin
			line_state_o <= hold_state;
		end else if (line_state_o == ugs_pkg::LINE_J) begin
			line_state_o <= ugs_pkg::LINE_K;
		end else begin
			line_state_o <= ugs_pkg::LINE_J;
		end
	end
	// Set on a rising edge so the falling-edge driver never races it
	task automatic hold(input logic [1:0] s, input int n);
		@(posedge clk_i);
		hold_state = s;
		hold_en = 1'b1;
		repeat (n) @(posedge clk_i);
		hold_en = 1'b0;
	endtask
endmodule
